// [hw/dwell_seq_consts.vh]
`ifndef DWELL_SEQ_CONSTS_VH
`define DWELL_SEQ_CONSTS_VH

// timing
`define CLK_HZ 32'h00989680
`define MS_PER_S 32'h000003E8
`define MS_PER_TENTH 24'h000064
`define CYC_PER_MS_DEF 16'h2710 // clk_hz / ms_per_s at the 10 MHz control clock

// register byte offsets
`define ADR_CTRL 8'h00
`define ADR_TERMFN_LO 8'h04
`define ADR_TERMFN_HI 8'h08
`define ADR_SET_FREQ 8'h0C
`define ADR_RAMP_TIME 8'h10
`define ADR_QSTOP_TIME 8'h14
`define ADR_DWELL_FREQ 8'h18
`define ADR_DWELL_TIME 8'h1C
`define ADR_FREQ_LIMIT 8'h20
`define ADR_STATUS 8'h24

// control fields
`define CTRL_GATE 0
`define CTRL_ACT_LO 1
`define CTRL_ACT_HI 2

// status fields
`define ST_STATE_LO 16
`define ST_STATE_HI 19
`define ST_BLOCK 20
`define ST_PERMIT 21
`define ST_GATING 22
`define ST_REARM 23

// terminal function code that makes a terminal the run permit
`define FN_RUN_PERMIT 8'h0D
`define FN_WIDTH 8

// permit-off stop actions
`define ACT_COAST 2'h0
`define ACT_QSTOP 2'h1
`define ACT_RESUME 2'h2

// reset values and limits (frequency in 0.01 Hz, time in 0.1 s)
`define RST_GATE 1'h1
`define RST_ACT 2'h0
`define RST_QSTOP_TIME 16'h0032
`define MAX_QSTOP_TIME 16'h1770
`define RST_DWELL_FREQ 16'h01F4
`define RST_DWELL_TIME 16'h0000
`define MAX_DWELL_TIME 16'h0064
`define RST_RAMP_TIME 16'h0064
`define RST_MAX_FREQ 16'h1770
`define RST_START_FREQ 16'h0032
`define RST_SET_FREQ 16'h0000

`endif

// [hw/hold_timer.v]
`timescale 1ns/1ps
`include "dwell_seq_consts.vh"

module hold_timer (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // control
   input wire tick_i,
   input wire load_i,
   input wire [15:0] tenths_i,
   // status
   output wire done_o
);

   reg [23:0] cnt_r;

   // counts down whole milliseconds; load wins over the count
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 24'h000000;
      end else if (ce_i) begin
         if (load_i) begin
            cnt_r <= {8'h00, tenths_i} * `MS_PER_TENTH;
         end else if (tick_i && cnt_r != 24'h000000) begin
            cnt_r <= cnt_r - 24'h000001;
         end
      end
   end

   assign done_o = (cnt_r == 24'h000000);

endmodule

// [hw/freq_ramp.v]
`timescale 1ns/1ps

module freq_ramp (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // control
   input wire tick_i,
   input wire zero_i,
   input wire [15:0] target_i,
   input wire [23:0] period_i,
   input wire [15:0] scale_i,
   // output
   output reg [15:0] freq_o,
   output wire at_target_o
);

   reg [24:0] acc_r;

   // fractional accumulator: scale_i lsb per period_i ms, one lsb per step
   always @(posedge clk_i) begin
      if (rst_i) begin
         freq_o <= 16'h0000;
         acc_r <= 25'h0000000;
      end else if (ce_i) begin
         if (zero_i) begin
            freq_o <= 16'h0000;
            acc_r <= 25'h0000000;
         end else if (freq_o == target_i) begin
            acc_r <= 25'h0000000;
         end else if (period_i == 24'h000000) begin
            freq_o <= target_i; // zero time jumps at once
         end else if (acc_r >= {1'b0, period_i}) begin
            acc_r <= acc_r - {1'b0, period_i};
            if (freq_o < target_i) begin
               freq_o <= freq_o + 16'h0001;
            end else begin
               freq_o <= freq_o - 16'h0001;
            end
         end else if (tick_i) begin
            acc_r <= acc_r + {9'h000, scale_i};
         end
      end
   end

   assign at_target_o = (freq_o == target_i);

endmodule

// [hw/run_permit_dwell_sequencer.v]
// Functional notes
// - terminal with function 13 is run permit
// - assignment alone does not enable gating
// - gated policy qualifies run with permit
// - always-enabled policy ignores permit terminal
// - action 0 blocks output at permit off
// - action 1 quick-stops, needs fresh run
// - action 2 quick-stops, resumes with run on
// - quick-stop time 0 to 600 s, 5.0
// - first accel holds at dwell frequency
// - stop decelerates, holds, then stops normally
// - zero hold time skips the plateau
// - accel hold only on first run
// - decel hold only after stop command
// - external brake control suppresses both holds
// - hold time 0-10 s, frequency bounded
`timescale 1ns/1ps
`include "dwell_seq_consts.vh"

module run_permit_dwell_sequencer #(
   parameter [15:0] CYC_PER_MS = `CYC_PER_MS_DEF
) (
   // clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // wishbone slave
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // drive commands and terminals
   input wire run_cmd_i,
   input wire [7:0] term_i,
   input wire brake_ctrl_i,
   // frequency command path
   output wire [15:0] freq_o,
   output reg block_o
);

   localparam S_IDLE = 4'h0;
   localparam S_ACC_RAMP = 4'h1;
   localparam S_ACC_HOLD = 4'h2;
   localparam S_RUN = 4'h3;
   localparam S_DEC_RAMP = 4'h4;
   localparam S_DEC_HOLD = 4'h5;
   localparam S_STOP = 4'h6;
   localparam S_QSTOP = 4'h7;
   localparam S_COAST = 4'h8;

   // byte-lane merge of a write into the old word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // bound a setting into its legal range
   function [15:0] clamp16;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if (v < lo) begin
            clamp16 = lo;
         end else if (v > hi) begin
            clamp16 = hi;
         end else begin
            clamp16 = v;
         end
      end
   endfunction

   // settings
   reg gate_r;
   reg [1:0] stop_act_r;
   reg [31:0] termfn_lo_r;
   reg [31:0] termfn_hi_r;
   reg [15:0] set_freq_r;
   reg [15:0] acc_time_r;
   reg [15:0] dec_time_r;
   reg [15:0] qstop_time_r;
   reg [15:0] acc_dw_freq_r;
   reg [15:0] dec_dw_freq_r;
   reg [15:0] acc_dw_time_r;
   reg [15:0] dec_dw_time_r;
   reg [15:0] max_freq_r;
   reg [15:0] start_freq_r;

   // sequencer state
   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg rearm_r;
   reg rearm_nxt;
   reg hold_load;
   reg [15:0] pre_r;
   reg [31:0] rd_data;
   reg [31:0] wr_word;
   reg [15:0] target;
   reg [23:0] period;

   wire [63:0] fn_all = {termfn_hi_r, termfn_lo_r};
   wire [7:0] permit_sel;
   wire [7:0] permit_on;
   wire gate_active;
   wire permit_ok;
   wire tick;
   wire at_target;
   wire hold_done;
   wire acc_dw_en;
   wire dec_dw_en;
   wire motion;
   wire bus_req;

   // terminal function decode, one field per terminal
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_term
         assign permit_sel[k] = (fn_all[k*`FN_WIDTH +: `FN_WIDTH] == `FN_RUN_PERMIT);
         assign permit_on[k] = permit_sel[k] & term_i[k];
      end
   endgenerate

   // gating needs both an assigned terminal and the gated policy
   assign gate_active = gate_r & (|permit_sel);
   assign permit_ok = ~gate_active | (|permit_on);

   // holds enabled only with nonzero time and no brake control
   assign acc_dw_en = (acc_dw_time_r != 16'h0000) & ~brake_ctrl_i
                      & (set_freq_r > acc_dw_freq_r);
   assign dec_dw_en = (dec_dw_time_r != 16'h0000) & ~brake_ctrl_i
                      & (freq_o > dec_dw_freq_r);
   assign motion = (state_r >= S_ACC_RAMP) && (state_r <= S_STOP);

   // millisecond prescaler paces ramps and holds
   assign tick = (pre_r == CYC_PER_MS - 16'h0001);
   always @(posedge clk_i) begin
      if (rst_i) begin
         pre_r <= 16'h0000;
      end else if (ce_i) begin
         if (tick) begin
            pre_r <= 16'h0000;
         end else begin
            pre_r <= pre_r + 16'h0001;
         end
      end
   end

   // register readback
   always @* begin
      case (wb_adr_i)
         `ADR_CTRL: rd_data = {29'h00000000, stop_act_r, gate_r};
         `ADR_TERMFN_LO: rd_data = termfn_lo_r;
         `ADR_TERMFN_HI: rd_data = termfn_hi_r;
         `ADR_SET_FREQ: rd_data = {16'h0000, set_freq_r};
         `ADR_RAMP_TIME: rd_data = {dec_time_r, acc_time_r};
         `ADR_QSTOP_TIME: rd_data = {16'h0000, qstop_time_r};
         `ADR_DWELL_FREQ: rd_data = {dec_dw_freq_r, acc_dw_freq_r};
         `ADR_DWELL_TIME: rd_data = {dec_dw_time_r, acc_dw_time_r};
         `ADR_FREQ_LIMIT: rd_data = {start_freq_r, max_freq_r};
         `ADR_STATUS: begin
            rd_data = 32'h00000000;
            rd_data[15:0] = freq_o;
            rd_data[`ST_STATE_HI:`ST_STATE_LO] = state_r;
            rd_data[`ST_BLOCK] = block_o;
            rd_data[`ST_PERMIT] = permit_ok;
            rd_data[`ST_GATING] = gate_active;
            rd_data[`ST_REARM] = rearm_r;
         end
         default: rd_data = 32'h00000000;
      endcase
      wr_word = merge(rd_data, wb_dat_i, wb_sel_i);
   end

   // one-wait-state slave; unmapped reads give zero, writes vanish
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // settings written; all but ramp times, limits and terminal codes range-checked at write time
   always @(posedge clk_i) begin
      if (rst_i) begin
         gate_r <= `RST_GATE;
         stop_act_r <= `RST_ACT;
         termfn_lo_r <= 32'h00000000;
         termfn_hi_r <= 32'h00000000;
         set_freq_r <= `RST_SET_FREQ;
         acc_time_r <= `RST_RAMP_TIME;
         dec_time_r <= `RST_RAMP_TIME;
         qstop_time_r <= `RST_QSTOP_TIME;
         acc_dw_freq_r <= `RST_DWELL_FREQ;
         dec_dw_freq_r <= `RST_DWELL_FREQ;
         acc_dw_time_r <= `RST_DWELL_TIME;
         dec_dw_time_r <= `RST_DWELL_TIME;
         max_freq_r <= `RST_MAX_FREQ;
         start_freq_r <= `RST_START_FREQ;
      end else if (ce_i && bus_req && wb_we_i) begin
         case (wb_adr_i)
            `ADR_CTRL: begin
               gate_r <= wr_word[`CTRL_GATE];
               // out-of-range action falls back to the safest resume-free stop
               if (wr_word[`CTRL_ACT_HI:`CTRL_ACT_LO] > `ACT_RESUME) begin
                  stop_act_r <= `ACT_QSTOP;
               end else begin
                  stop_act_r <= wr_word[`CTRL_ACT_HI:`CTRL_ACT_LO];
               end
            end
            `ADR_TERMFN_LO: termfn_lo_r <= wr_word;
            `ADR_TERMFN_HI: termfn_hi_r <= wr_word;
            `ADR_SET_FREQ: set_freq_r <= clamp16(wr_word[15:0], 16'h0000, max_freq_r);
            `ADR_RAMP_TIME: begin
               acc_time_r <= wr_word[15:0];
               dec_time_r <= wr_word[31:16];
            end
            `ADR_QSTOP_TIME: begin
               qstop_time_r <= clamp16(wr_word[15:0], 16'h0000, `MAX_QSTOP_TIME);
            end
            `ADR_DWELL_FREQ: begin
               acc_dw_freq_r <= clamp16(wr_word[15:0], start_freq_r, max_freq_r);
               dec_dw_freq_r <= clamp16(wr_word[31:16], start_freq_r, max_freq_r);
            end
            `ADR_DWELL_TIME: begin
               acc_dw_time_r <= clamp16(wr_word[15:0], 16'h0000, `MAX_DWELL_TIME);
               dec_dw_time_r <= clamp16(wr_word[31:16], 16'h0000, `MAX_DWELL_TIME);
            end
            `ADR_FREQ_LIMIT: begin
               max_freq_r <= wr_word[15:0];
               start_freq_r <= wr_word[31:16];
            end
            default: begin
            end
         endcase
      end
   end

   // sequencer next state
   always @* begin
      state_nxt = state_r;
      rearm_nxt = rearm_r;
      hold_load = 1'b0;
      if (!run_cmd_i) begin
         rearm_nxt = 1'b0; // run released: a new run may start
      end
      case (state_r)
         S_IDLE: begin
            if (run_cmd_i && permit_ok && !rearm_r) begin
               if (acc_dw_en) begin
                  state_nxt = S_ACC_RAMP;
               end else begin
                  state_nxt = S_RUN;
               end
            end
         end
         S_ACC_RAMP: begin
            if (!run_cmd_i) begin
               state_nxt = S_STOP;
            end else if (at_target) begin
               state_nxt = S_ACC_HOLD;
               hold_load = 1'b1;
            end
         end
         S_ACC_HOLD: begin
            if (!run_cmd_i) begin
               state_nxt = S_STOP;
            end else if (hold_done || brake_ctrl_i) begin
               state_nxt = S_RUN;
            end
         end
         S_RUN: begin
            if (!run_cmd_i) begin
               if (dec_dw_en) begin
                  state_nxt = S_DEC_RAMP;
               end else begin
                  state_nxt = S_STOP;
               end
            end
         end
         S_DEC_RAMP: begin
            if (run_cmd_i) begin
               state_nxt = S_RUN;
            end else if (at_target) begin
               state_nxt = S_DEC_HOLD;
               hold_load = 1'b1;
            end
         end
         S_DEC_HOLD: begin
            if (run_cmd_i) begin
               state_nxt = S_RUN;
            end else if (hold_done || brake_ctrl_i) begin
               state_nxt = S_STOP;
            end
         end
         S_STOP: begin
            if (run_cmd_i) begin
               state_nxt = S_RUN;
            end else if (freq_o == 16'h0000) begin
               state_nxt = S_IDLE;
            end
         end
         S_QSTOP: begin
            if (stop_act_r == `ACT_RESUME && run_cmd_i && permit_ok) begin
               state_nxt = S_RUN;
            end else if (freq_o == 16'h0000 &&
                         (stop_act_r != `ACT_RESUME || !run_cmd_i)) begin
               state_nxt = S_IDLE;
            end
         end
         S_COAST: begin
            if (permit_ok || !run_cmd_i) begin
               state_nxt = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
      // permit loss overrides every motion state
      if (motion && !permit_ok) begin
         if (stop_act_r == `ACT_COAST) begin
            state_nxt = S_COAST;
            rearm_nxt = 1'b1;
         end else begin
            state_nxt = S_QSTOP;
            rearm_nxt = (stop_act_r == `ACT_QSTOP);
         end
      end
   end

   // ramp target and rate by state
   always @* begin
      target = 16'h0000;
      case (state_r)
         S_ACC_RAMP: target = acc_dw_freq_r;
         S_ACC_HOLD: target = freq_o;
         S_RUN: target = set_freq_r;
         S_DEC_RAMP: target = dec_dw_freq_r;
         S_DEC_HOLD: target = freq_o;
         default: target = 16'h0000;
      endcase
      if (state_r == S_QSTOP) begin
         period = {8'h00, qstop_time_r} * `MS_PER_TENTH;
      end else if (freq_o < target) begin
         period = {8'h00, acc_time_r} * `MS_PER_TENTH;
      end else begin
         period = {8'h00, dec_time_r} * `MS_PER_TENTH;
      end
   end

   // state, rearm and output block
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
         rearm_r <= 1'b0;
         block_o <= 1'b0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         rearm_r <= rearm_nxt;
         block_o <= (state_nxt == S_COAST);
      end
   end

   // linear ramp; full scale is the maximum frequency
   freq_ramp u_ramp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .tick_i(tick),
      .zero_i(state_r == S_COAST || state_r == S_IDLE),
      .target_i(target),
      .period_i(period),
      .scale_i(max_freq_r),
      .freq_o(freq_o),
      .at_target_o(at_target)
   );

   // shared plateau timer for both holds
   hold_timer u_hold (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .tick_i(tick),
      .load_i(hold_load),
      .tenths_i(state_r == S_ACC_RAMP ? acc_dw_time_r : dec_dw_time_r),
      .done_o(hold_done)
   );

endmodule

// [test/run_permit_dwell_sequencer_assertions.sv]
`timescale 1ns/1ps
`include "dwell_seq_consts.vh"

module seq_checker #(
   parameter [15:0] CYC_PER_MS = 16'h000A
) (
   // clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // wishbone slave
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // drive side
   input wire run_cmd_i,
   input wire [7:0] term_i,
   input wire brake_ctrl_i,
   input wire [15:0] freq_o,
   input wire block_o
);
   reg gate_r;
   reg [1:0] act_r;
   wire take_w;

   // policy and action are snooped off the bus, the body is hidden
   assign take_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i &&
      wb_adr_i == `ADR_CTRL && wb_sel_i[0];
   always @(posedge clk_i) begin
      if (rst_i) begin
         gate_r <= 1'b1;
         act_r <= 2'h0;
      end else if (take_w) begin
         gate_r <= wb_dat_i[0];
         act_r <= wb_dat_i[2:1];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_RESET_CLEARS:
      assert property (disable iff (1'b0) rst_i && ce_i |=> freq_o == 16'h0000 && !block_o)
      else $error("outputs not cleared by reset");
   AST_ACK_PULSE:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   AST_ACK_ANSWER:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("bus request not acknowledged");
   AST_DAT_HOLDS:
      assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
   AST_UNMAPPED_ZERO:
      assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce_i &&
         wb_adr_i >= 8'h28 |=> wb_dat_o == 32'h00000000) else $error("unmapped read not 0");
   AST_STOP_NO_RISE:
      assert property (!run_cmd_i && !$past(run_cmd_i) && !$past(run_cmd_i, 2)
         |=> freq_o <= $past(freq_o)) else $error("frequency rose under stop");
   AST_UNGATED_NO_COAST:
      assert property (!gate_r && !$past(gate_r) && !$past(gate_r, 2) |-> !$rose(block_o))
      else $error("coast while gating off");
   AST_QSTOP_NO_COAST:
      assert property (act_r != 2'h0 && $past(act_r) != 2'h0 && $past(act_r, 2) != 2'h0
         |-> !$rose(block_o)) else $error("coast with quick stop action");
   AST_COAST_RELEASE:
      assert property (block_o && !run_cmd_i |-> ##[1:2] !block_o)
      else $error("block held after run dropped");

   // main scenarios
   cover property ($rose(block_o));
   cover property (freq_o == 16'h01F4 && run_cmd_i && !brake_ctrl_i);
   cover property (wb_ack_o && !wb_we_i);
endmodule

bind run_permit_dwell_sequencer seq_checker #(.CYC_PER_MS(CYC_PER_MS)) seq_checker_inst (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_cmd_i(run_cmd_i), .term_i(term_i),
   .brake_ctrl_i(brake_ctrl_i), .freq_o(freq_o), .block_o(block_o));

// [test/testbench.sv]
`timescale 1ns/1ps
`include "dwell_seq_consts.vh"

module testbench;
   // stimulus and observed signals
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [7:0] wb_adr_i = 8'h00;
   reg [31:0] wb_dat_i = 32'h00000000;
   reg wb_we_i = 1'b0;
   reg wb_cyc_i = 1'b0;
   reg wb_stb_i = 1'b0;
   reg [3:0] wb_sel_i = 4'h0;
   reg [3:0] lanes = 4'hF;
   reg ce_i = 1'b1;
   reg run_cmd_i = 1'b0;
   reg [7:0] term_i = 8'h00;
   reg brake_ctrl_i = 1'b0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o;
   wire [15:0] freq_o;
   wire block_o;
   integer errors = 0;
   integer total_checks = 0;
   reg [63:0] notes[$];
   reg [63:0] note;
   reg [31:0] seed = 32'h0000F4C7;
   reg [15:0] f;
   reg [15:0] g;

   always #50 clk_i = ~clk_i;

   // ms tick every 10 clocks keeps holds near 1000 cycles
   run_permit_dwell_sequencer #(.CYC_PER_MS(16'h000A)) run_permit_dwell_sequencer_inst (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_cmd_i(run_cmd_i), .term_i(term_i),
      .brake_ctrl_i(brake_ctrl_i), .freq_o(freq_o), .block_o(block_o));

   function [31:0] xorshift(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xorshift = x ^ (x << 5);
      end
   endfunction

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task give_verdict;
      begin
         if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   // one classic cycle; a read leaves its expectation in the queue
   task bus(input [7:0] a, input w, input [31:0] d, input [31:0] m);
      begin
         @(posedge clk_i);
         wb_adr_i <= a;
         wb_we_i <= w;
         wb_dat_i <= w ? d : 32'h00000000;
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_sel_i <= lanes;
         if (!w)
            notes.push_back({m, d & m});
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1) @(posedge clk_i);
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
         wb_sel_i <= 4'h0;
      end
   endtask

   // status: block bit, state and frequency
   task st(input [3:0] s, input [15:0] fr);
      bus(`ADR_STATUS, 1'b0, {12'h000, s, fr}, 32'h001FFFFF);
   endtask

   task go(input [7:0] t, input r, input integer n);
      begin
         term_i <= t;
         run_cmd_i <= r;
         repeat (n) @(posedge clk_i);
      end
   endtask

   // read data is judged at the ack edge, before the master lets go
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
         note = notes.pop_front();
         chk(wb_dat_o & note[63:32], note[31:0]);
      end
   end

   // bench needs about 11000 cycles; a hang stops at 60000
   initial begin
      #6000000;
      errors = errors + 1;
      give_verdict;
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(`ADR_CTRL, 1'b0, 32'h00000001, 32'h00000007);
      bus(`ADR_QSTOP_TIME, 1'b0, 32'h00000032, 32'h0000FFFF);
      bus(`ADR_DWELL_FREQ, 1'b0, 32'h01F401F4, 32'hFFFFFFFF);
      bus(`ADR_DWELL_TIME, 1'b0, 32'h00000000, 32'hFFFFFFFF);
      bus(8'h30, 1'b0, 32'h00000000, 32'hFFFFFFFF);
      bus(`ADR_STATUS, 1'b1, 32'hFFFFFFFF, 32'h00000000);
      st(4'h0, 16'h0000);
      // out-of-range settings are clamped
      bus(`ADR_QSTOP_TIME, 1'b1, 32'h0000FFFF, 32'h00000000);
      bus(`ADR_QSTOP_TIME, 1'b0, 32'h00001770, 32'h0000FFFF);
      bus(`ADR_DWELL_TIME, 1'b1, 32'hFFFFFFFF, 32'h00000000);
      bus(`ADR_DWELL_TIME, 1'b0, 32'h00640064, 32'hFFFFFFFF);
      bus(`ADR_DWELL_FREQ, 1'b1, 32'h00000000, 32'h00000000);
      bus(`ADR_DWELL_FREQ, 1'b0, 32'h00320032, 32'hFFFFFFFF);
      // upper lanes only: the low half keeps its value
      lanes = 4'hC;
      bus(`ADR_DWELL_FREQ, 1'b1, 32'h01F40000, 32'h00000000);
      lanes = 4'hF;
      bus(`ADR_DWELL_FREQ, 1'b0, 32'h01F40032, 32'hFFFFFFFF);
      // instant ramps keep plateaus easy to see
      bus(`ADR_RAMP_TIME, 1'b1, 32'h00000000, 32'h00000000);
      bus(`ADR_DWELL_FREQ, 1'b1, 32'h01F401F4, 32'h00000000);
      bus(`ADR_DWELL_TIME, 1'b1, 32'h00000000, 32'h00000000);
      bus(`ADR_QSTOP_TIME, 1'b1, 32'h00000001, 32'h00000000);
      seed = xorshift(seed);
      f = 16'h03E8 + {4'h0, seed[11:0]};
      bus(`ADR_SET_FREQ, 1'b1, {16'h0000, f}, 32'h00000000);
      // policy alone, no terminal coded, zero hold times
      go(seed[23:16], 1'b1, 5);
      st(4'h3, f);
      bus(`ADR_STATUS, 1'b0, 32'h00000000, 32'h00400000);
      go(seed[23:16], 1'b0, 5);
      st(4'h0, 16'h0000);
      // terminal 2 becomes the permit
      bus(`ADR_TERMFN_LO, 1'b1, 32'h000D0000, 32'h00000000);
      go(seed[31:24] & 8'hFB, 1'b1, 5);
      st(4'h0, 16'h0000);
      bus(`ADR_STATUS, 1'b0, 32'h00400000, 32'h00400000);
      go(8'h04, 1'b1, 5);
      st(4'h3, f);
      // acceleration and deceleration plateaus
      go(8'h04, 1'b0, 5);
      bus(`ADR_DWELL_TIME, 1'b1, 32'h00010001, 32'h00000000);
      go(8'h04, 1'b1, 5);
      st(4'h2, 16'h01F4);
      go(8'h04, 1'b1, 1100);
      st(4'h3, f);
      go(8'h04, 1'b0, 5);
      st(4'h5, 16'h01F4);
      go(8'h04, 1'b0, 1100);
      st(4'h0, 16'h0000);
      go(8'h04, 1'b1, 1105);
      go(8'h04, 1'b0, 5);
      go(8'h04, 1'b1, 5);
      st(4'h3, f);
      bus(`ADR_SET_FREQ, 1'b1, 32'h0000012C, 32'h00000000);
      go(8'h04, 1'b1, 5);
      st(4'h3, 16'h012C);
      go(8'h04, 1'b0, 5);
      st(4'h0, 16'h0000);
      // brake control suppresses both plateaus
      brake_ctrl_i <= 1'b1;
      bus(`ADR_SET_FREQ, 1'b1, 32'h00000BB8, 32'h00000000);
      go(8'h04, 1'b1, 5);
      st(4'h3, 16'h0BB8);
      go(8'h04, 1'b0, 5);
      st(4'h0, 16'h0000);
      brake_ctrl_i <= 1'b0;
      bus(`ADR_DWELL_TIME, 1'b1, 32'h00000000, 32'h00000000);
      // coast on permit loss, released by run low
      go(8'h04, 1'b1, 5);
      go(8'h00, 1'b1, 3);
      chk({31'h0, block_o}, 32'h00000001);
      bus(`ADR_STATUS, 1'b0, 32'h00180000, 32'h001F0000);
      go(8'h00, 1'b0, 5);
      st(4'h0, 16'h0000);
      // quick stop waits for a fresh run
      bus(`ADR_CTRL, 1'b1, 32'h00000003, 32'h00000000);
      go(8'h04, 1'b1, 5);
      go(8'h00, 1'b1, 25);
      chk({31'h0, freq_o < 16'h0BB8 && freq_o > 16'h0A00}, 32'h00000001);
      bus(`ADR_STATUS, 1'b0, 32'h00070000, 32'h001F0000);
      go(8'h00, 1'b1, 600);
      // permit back mid-ramp; the ramp moves one step a clock at most here
      go(8'h04, 1'b1, 3000);
      bus(`ADR_STATUS, 1'b0, 32'h00800000, 32'h009FFFFF);
      go(8'h04, 1'b0, 5);
      go(8'h04, 1'b1, 5);
      st(4'h3, 16'h0BB8);
      // quick stop with automatic resume
      bus(`ADR_CTRL, 1'b1, 32'h00000005, 32'h00000000);
      go(8'h00, 1'b1, 600);
      // clock enable low freezes the ramp mid-way
      ce_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      g = freq_o;
      repeat (100) @(posedge clk_i);
      chk({16'h0000, freq_o}, {16'h0000, g});
      ce_i <= 1'b1;
      go(8'h00, 1'b1, 3000);
      st(4'h7, 16'h0000);
      go(8'h04, 1'b1, 10);
      st(4'h3, 16'h0BB8);
      // always enabled ignores the terminal
      bus(`ADR_CTRL, 1'b1, 32'h00000000, 32'h00000000);
      go(8'h00, 1'b0, 5);
      go(8'h00, 1'b1, 5);
      st(4'h3, 16'h0BB8);
      bus(`ADR_STATUS, 1'b0, 32'h00000000, 32'h00400000);
      go(8'h00, 1'b0, 5);
      give_verdict;
   end
endmodule
